// ### common/bau_regs.vh
// Register map, field positions, opcodes and reset values of the byte arithmetic unit
`ifndef BAU_REGS_VH
`define BAU_REGS_VH

`define BAU_OFS_CTRL       8'h00
`define BAU_OFS_OPERAND    8'h04
`define BAU_OFS_WREG       8'h08
`define BAU_OFS_FLAGS      8'h0C
`define BAU_OFS_MULOP      8'h10
`define BAU_OFS_MULRH      8'h14
`define BAU_OFS_MEMRES     8'h18
`define BAU_OFS_STATUS     8'h1C

`define BAU_FLG_ZERO       0
`define BAU_FLG_CARRY      1
`define BAU_FLG_NIBBLE     2
`define BAU_FLG_SIGNED     3

`define BAU_STS_MEM_DST    0
`define BAU_STS_OP_OK      1

`define BAU_RST_BYTE       8'h00
`define BAU_RST_WORD       32'h0000_0000
`define BAU_RST_OP         5'h00

`define BAU_OP_ADD_AI      5'h01
`define BAU_OP_ADD_AM      5'h02
`define BAU_OP_ADD_MA      5'h03
`define BAU_OP_ADDC_AM     5'h04
`define BAU_OP_ADDC_MA     5'h05
`define BAU_OP_ADDC_A      5'h06
`define BAU_OP_ADDC_M      5'h07
`define BAU_OP_NADD_AM     5'h08
`define BAU_OP_NADD_MA     5'h09
`define BAU_OP_SUB_AI      5'h0A
`define BAU_OP_SUB_AM      5'h0B
`define BAU_OP_SUB_MA      5'h0C
`define BAU_OP_SUBC_AM     5'h0D
`define BAU_OP_SUBC_MA     5'h0E
`define BAU_OP_SUBC_A      5'h0F
`define BAU_OP_SUBC_M      5'h10
`define BAU_OP_INC_M       5'h11
`define BAU_OP_DEC_M       5'h12
`define BAU_OP_CLR_M       5'h13
`define BAU_OP_MUL         5'h14

`endif

// ### hw/bau_core.v
// Byte arithmetic unit with flags, multiplier and Avalon-MM register slave
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bau_regs.vh"

module bau_core (
    input  wire        sys_clk,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg  [7:0]  mem_wr_data,
    output reg         mem_wr_stb
);

    reg  [7:0]  working_register_reg;
    reg  [7:0]  operand_reg;
    reg  [7:0]  mulop_reg;
    reg  [7:0]  mulrh_reg;
    reg  [7:0]  memres_reg;
    reg  [4:0]  last_op_reg;
    reg         zero_flag_reg;
    reg         carry_flag_reg;
    reg         nibble_spill_flag_reg;
    reg         signed_range_flag_reg;
    reg         mem_dst_reg;
    reg         op_ok_reg;

    reg  [7:0]  x_op;
    reg  [7:0]  y_raw;
    reg         sub_mode;
    reg         cin_bit;
    reg         dst_mem;
    reg         arith_op;
    reg         clr_op;
    reg         mul_op;
    reg         op_ok;
    reg  [31:0] rd_mux;

    wire        bus_take;
    wire        wr_take;
    wire        lane0;
    wire        ctrl_exec;
    wire [4:0]  op_code;
    wire [7:0]  y_eff;
    wire        cin_eff;
    wire [8:0]  sum9;
    wire [4:0]  low5;
    wire [7:0]  res;
    wire        res_ovf;
    wire [15:0] prod;

    // Access completes on the edge that sees waitrequest low
    assign bus_take  = (avs_read | avs_write) & ~avs_waitrequest;
    assign wr_take   = clk_en & avs_write & ~avs_waitrequest;
    assign lane0     = avs_byteenable[0];
    assign ctrl_exec = wr_take & lane0 & (avs_address == `BAU_OFS_CTRL);
    assign op_code   = avs_writedata[4:0];

    // Operand decode per opcode
    always @* begin
        x_op     = working_register_reg;
        y_raw    = operand_reg;
        sub_mode = 1'b0;
        cin_bit  = 1'b0;
        dst_mem  = 1'b0;
        arith_op = 1'b0;
        clr_op   = 1'b0;
        mul_op   = 1'b0;
        op_ok    = 1'b1;
        case (op_code)
            `BAU_OP_ADD_AI: begin
                arith_op = 1'b1;
            end
            `BAU_OP_ADD_AM: begin
                arith_op = 1'b1;
            end
            `BAU_OP_ADD_MA: begin
                arith_op = 1'b1;
                dst_mem  = 1'b1;
            end
            `BAU_OP_ADDC_AM: begin
                arith_op = 1'b1;
                cin_bit  = carry_flag_reg;
            end
            `BAU_OP_ADDC_MA: begin
                arith_op = 1'b1;
                cin_bit  = carry_flag_reg;
                dst_mem  = 1'b1;
            end
            `BAU_OP_ADDC_A: begin
                arith_op = 1'b1;
                y_raw    = `BAU_RST_BYTE;
                cin_bit  = carry_flag_reg;
            end
            `BAU_OP_ADDC_M: begin
                arith_op = 1'b1;
                x_op     = operand_reg;
                y_raw    = `BAU_RST_BYTE;
                cin_bit  = carry_flag_reg;
                dst_mem  = 1'b1;
            end
            `BAU_OP_NADD_AM: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
                x_op     = operand_reg;
                y_raw    = working_register_reg;
            end
            `BAU_OP_NADD_MA: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
                dst_mem  = 1'b1;
            end
            `BAU_OP_SUB_AI: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
            end
            `BAU_OP_SUB_AM: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
            end
            `BAU_OP_SUB_MA: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
                x_op     = operand_reg;
                y_raw    = working_register_reg;
                dst_mem  = 1'b1;
            end
            `BAU_OP_SUBC_AM: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
                cin_bit  = carry_flag_reg;
            end
            `BAU_OP_SUBC_MA: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
                x_op     = operand_reg;
                y_raw    = working_register_reg;
                cin_bit  = carry_flag_reg;
                dst_mem  = 1'b1;
            end
            `BAU_OP_SUBC_A: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
                y_raw    = `BAU_RST_BYTE;
                cin_bit  = carry_flag_reg;
            end
            `BAU_OP_SUBC_M: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
                x_op     = operand_reg;
                y_raw    = `BAU_RST_BYTE;
                cin_bit  = carry_flag_reg;
                dst_mem  = 1'b1;
            end
            `BAU_OP_INC_M: begin
                arith_op = 1'b1;
                x_op     = operand_reg;
                y_raw    = `BAU_RST_BYTE;
                cin_bit  = 1'b1;
                dst_mem  = 1'b1;
            end
            `BAU_OP_DEC_M: begin
                arith_op = 1'b1;
                sub_mode = 1'b1;
                x_op     = operand_reg;
                y_raw    = `BAU_RST_BYTE;
                cin_bit  = 1'b1;
                dst_mem  = 1'b1;
            end
            `BAU_OP_CLR_M: begin
                clr_op   = 1'b1;
                dst_mem  = 1'b1;
            end
            `BAU_OP_MUL: begin
                mul_op   = 1'b1;
            end
            default: begin
                op_ok    = 1'b0;
            end
        endcase
    end

    // Subtract as x plus inverted y with inverted borrow in
    assign y_eff   = sub_mode ? ~y_raw : y_raw;
    assign cin_eff = sub_mode ? ~cin_bit : cin_bit;
    assign sum9    = {1'b0, x_op} + {1'b0, y_eff} + {8'h00, cin_eff};
    assign low5    = {1'b0, x_op[3:0]} + {1'b0, y_eff[3:0]} + {4'h0, cin_eff};
    assign res     = sum9[7:0];
    assign res_ovf = (x_op[7] == y_eff[7]) & (res[7] != x_op[7]);
    assign prod    = working_register_reg * mulop_reg;

    // Read data selection
    always @* begin
        rd_mux = `BAU_RST_WORD;
        case (avs_address)
            `BAU_OFS_CTRL: begin
                rd_mux[4:0] = last_op_reg;
            end
            `BAU_OFS_OPERAND: begin
                rd_mux[7:0] = operand_reg;
            end
            `BAU_OFS_WREG: begin
                rd_mux[7:0] = working_register_reg;
            end
            `BAU_OFS_FLAGS: begin
                rd_mux[`BAU_FLG_ZERO]   = zero_flag_reg;
                rd_mux[`BAU_FLG_CARRY]  = carry_flag_reg;
                rd_mux[`BAU_FLG_NIBBLE] = nibble_spill_flag_reg;
                rd_mux[`BAU_FLG_SIGNED] = signed_range_flag_reg;
            end
            `BAU_OFS_MULOP: begin
                rd_mux[7:0] = mulop_reg;
            end
            `BAU_OFS_MULRH: begin
                rd_mux[7:0] = mulrh_reg;
            end
            `BAU_OFS_MEMRES: begin
                rd_mux[7:0] = memres_reg;
            end
            `BAU_OFS_STATUS: begin
                rd_mux[`BAU_STS_MEM_DST] = mem_dst_reg;
                rd_mux[`BAU_STS_OP_OK]   = op_ok_reg;
            end
            default: begin
                rd_mux = `BAU_RST_WORD;
            end
        endcase
    end

    // Bus handshake: one wait cycle, then a single ready cycle
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `BAU_RST_WORD;
        end else if (clk_en) begin
            if (bus_take || !(avs_read || avs_write)) begin
                avs_waitrequest <= 1'b1;
            end else begin
                avs_waitrequest <= 1'b0;
                if (avs_read) begin
                    avs_readdata <= rd_mux;
                end
            end
        end
    end

    // Register writes and operation execution
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            working_register_reg  <= `BAU_RST_BYTE;
            operand_reg           <= `BAU_RST_BYTE;
            mulop_reg             <= `BAU_RST_BYTE;
            mulrh_reg             <= `BAU_RST_BYTE;
            memres_reg            <= `BAU_RST_BYTE;
            last_op_reg           <= `BAU_RST_OP;
            zero_flag_reg         <= 1'b0;
            carry_flag_reg        <= 1'b0;
            nibble_spill_flag_reg <= 1'b0;
            signed_range_flag_reg <= 1'b0;
            mem_dst_reg           <= 1'b0;
            op_ok_reg             <= 1'b0;
            mem_wr_data           <= `BAU_RST_BYTE;
            mem_wr_stb            <= 1'b0;
        end else if (clk_en) begin
            mem_wr_stb <= 1'b0;
            if (wr_take && lane0) begin
                case (avs_address)
                    `BAU_OFS_OPERAND: begin
                        operand_reg <= avs_writedata[7:0];
                    end
                    `BAU_OFS_WREG: begin
                        working_register_reg <= avs_writedata[7:0];
                    end
                    `BAU_OFS_FLAGS: begin
                        zero_flag_reg         <= avs_writedata[`BAU_FLG_ZERO];
                        carry_flag_reg        <= avs_writedata[`BAU_FLG_CARRY];
                        nibble_spill_flag_reg <= avs_writedata[`BAU_FLG_NIBBLE];
                        signed_range_flag_reg <= avs_writedata[`BAU_FLG_SIGNED];
                    end
                    `BAU_OFS_MULOP: begin
                        mulop_reg <= avs_writedata[7:0];
                    end
                    default: begin
                        mulop_reg <= mulop_reg;
                    end
                endcase
            end
            if (ctrl_exec) begin
                last_op_reg <= op_code;
                op_ok_reg   <= op_ok;
                mem_dst_reg <= dst_mem;
                if (arith_op) begin
                    zero_flag_reg         <= (res == `BAU_RST_BYTE);
                    carry_flag_reg        <= sub_mode ? ~sum9[8] : sum9[8];
                    nibble_spill_flag_reg <= sub_mode ? ~low5[4] : low5[4];
                    signed_range_flag_reg <= res_ovf;
                    if (dst_mem) begin
                        memres_reg  <= res;
                        mem_wr_data <= res;
                        mem_wr_stb  <= 1'b1;
                    end else begin
                        working_register_reg <= res;
                    end
                end
                if (clr_op) begin
                    memres_reg  <= `BAU_RST_BYTE;
                    mem_wr_data <= `BAU_RST_BYTE;
                    mem_wr_stb  <= 1'b1;
                end
                if (mul_op) begin
                    working_register_reg <= prod[7:0];
                    mulrh_reg            <= prod[15:8];
                end
            end
        end
    end

endmodule
`default_nettype wire

// ### tb/bau_core_properties.sv
// Concurrent checks on the port behaviour of the byte arithmetic unit
`timescale 1ns/1ps
`default_nettype none
`include "bau_regs.vh"
module bau_core_properties (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        clk_en,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [7:0]  mem_wr_data,
    input wire logic        mem_wr_stb
);
    logic [7:0] opnd_reg;
    wire logic  wr_take = avs_write && !avs_waitrequest && clk_en && avs_byteenable[0];
    wire logic  ctrl_take = wr_take && (avs_address == `BAU_OFS_CTRL);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // Shadow of the memory operand register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            opnd_reg <= `BAU_RST_BYTE;
        else if (wr_take && avs_address == `BAU_OFS_OPERAND)
            opnd_reg <= avs_writedata[7:0];
    end

    sequence s_exec(logic [4:0] op);
        ctrl_take && (avs_writedata[4:0] == op);
    endsequence
    sequence s_mem_out(logic [7:0] v);
        mem_wr_stb && (mem_wr_data == v);
    endsequence

    property p_clear; s_exec(`BAU_OP_CLR_M) |=> s_mem_out(8'h00); endproperty
    a_clear: assert property (p_clear) else $error("clear wrote nonzero");
    property p_inc; s_exec(`BAU_OP_INC_M) |=> s_mem_out(opnd_reg + 8'h01); endproperty
    a_inc: assert property (p_inc) else $error("increment result wrong");
    property p_dec; s_exec(`BAU_OP_DEC_M) |=> s_mem_out(opnd_reg - 8'h01); endproperty
    a_dec: assert property (p_dec) else $error("decrement result wrong");
    property p_addc_m;
        s_exec(`BAU_OP_ADDC_M) |=> mem_wr_stb &&
            (mem_wr_data == opnd_reg || mem_wr_data == opnd_reg + 8'h01);
    endproperty
    a_addc_m: assert property (p_addc_m) else $error("carry add on memory wrong");
    property p_subc_m;
        s_exec(`BAU_OP_SUBC_M) |=> mem_wr_stb &&
            (mem_wr_data == opnd_reg || mem_wr_data == opnd_reg - 8'h01);
    endproperty
    a_subc_m: assert property (p_subc_m) else $error("borrow on memory wrong");
    property p_reg_dst; s_exec(`BAU_OP_ADD_AI) |=> !mem_wr_stb; endproperty
    a_reg_dst: assert property (p_reg_dst) else $error("immediate add hit memory");
    property p_mul; s_exec(`BAU_OP_MUL) |=> !mem_wr_stb [*2]; endproperty
    a_mul: assert property (p_mul) else $error("multiply hit memory");
    property p_cause; $rose(mem_wr_stb) |-> $past(ctrl_take); endproperty
    a_cause: assert property (p_cause) else $error("memory write without command");
    property p_pulse; mem_wr_stb && clk_en |=> !mem_wr_stb; endproperty
    a_pulse: assert property (p_pulse) else $error("memory strobe too long");
endmodule
`default_nettype wire

// ### tb/bau_core_bench.sv
// Self-checking bench for the byte arithmetic unit
`timescale 1ns/1ps
`default_nettype none
`include "bau_regs.vh"
module bau_core_bench;
    typedef struct {logic [7:0] a; logic [7:0] m; logic [3:0] f;} bau_row_t;
    logic        sys_clk;
    logic        arst_n;
    logic        clk_en;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  mem_wr_data;
    logic        mem_wr_stb;
    logic [7:0]  stb_data;
    logic [31:0] rd;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          stb_cnt = 0;
    bau_row_t    rows [4] = '{'{8'h7F, 8'h01, 4'h2}, '{8'h01, 8'hFF, 4'h0},
                              '{8'h00, 8'h00, 4'h2}, '{8'h80, 8'h01, 4'hF}};
    logic [7:0]  rst_ofs [8] = '{`BAU_OFS_WREG, `BAU_OFS_FLAGS, `BAU_OFS_MULRH,
                                 `BAU_OFS_MEMRES, `BAU_OFS_OPERAND, `BAU_OFS_MULOP,
                                 `BAU_OFS_STATUS, `BAU_OFS_CTRL};

    bau_core uut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mem_wr_data(mem_wr_data), .mem_wr_stb(mem_wr_stb));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (mem_wr_stb === 1'b1) begin
            stb_cnt++;
            stb_data = mem_wr_data;
        end
        if (cycles > 20000) begin
            miscompares++;
            stop_test;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= ad;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Returns {memory destination, flags, result} from plain arithmetic
    function automatic logic [12:0] ref_op(input logic [4:0] op, input bau_row_t r);
        logic [7:0] x;
        logic [7:0] y;
        logic       ci;
        logic       sb;
        logic       md;
        logic       vf;
        logic [8:0] s;
        logic [4:0] h;
        if (op == `BAU_OP_CLR_M)
            return {1'b1, r.f, 8'h00};
        if (op == 5'h00 || op > `BAU_OP_CLR_M)
            return {1'b0, r.f, r.a};
        case (op)
            `BAU_OP_ADDC_M, `BAU_OP_NADD_AM, `BAU_OP_SUB_MA, `BAU_OP_SUBC_MA,
            `BAU_OP_SUBC_M, `BAU_OP_INC_M, `BAU_OP_DEC_M: x = r.m;
            default: x = r.a;
        endcase
        case (op)
            `BAU_OP_NADD_AM, `BAU_OP_SUB_MA, `BAU_OP_SUBC_MA: y = r.a;
            `BAU_OP_ADDC_A, `BAU_OP_ADDC_M, `BAU_OP_SUBC_A, `BAU_OP_SUBC_M,
            `BAU_OP_INC_M, `BAU_OP_DEC_M: y = 8'h00;
            default: y = r.m;
        endcase
        case (op)
            `BAU_OP_ADDC_AM, `BAU_OP_ADDC_MA, `BAU_OP_ADDC_A, `BAU_OP_ADDC_M,
            `BAU_OP_SUBC_AM, `BAU_OP_SUBC_MA, `BAU_OP_SUBC_A, `BAU_OP_SUBC_M: ci = r.f[1];
            `BAU_OP_INC_M, `BAU_OP_DEC_M: ci = 1'b1;
            default: ci = 1'b0;
        endcase
        sb = (op >= `BAU_OP_NADD_AM) && (op != `BAU_OP_INC_M);
        case (op)
            `BAU_OP_ADD_MA, `BAU_OP_ADDC_MA, `BAU_OP_ADDC_M, `BAU_OP_NADD_MA, `BAU_OP_SUB_MA,
            `BAU_OP_SUBC_MA, `BAU_OP_SUBC_M, `BAU_OP_INC_M, `BAU_OP_DEC_M: md = 1'b1;
            default: md = 1'b0;
        endcase
        // Borrow shows as the wrap of a zero-extended difference
        if (sb) begin
            s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
            h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
            vf = (x[7] != y[7]) && (s[7] != x[7]);
        end else begin
            s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
            h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
            vf = (x[7] == y[7]) && (s[7] != x[7]);
        end
        return {md, vf, h[4], s[8], (s[7:0] == 8'h00), s[7:0]};
    endfunction

    task automatic run_row(input logic [4:0] op, input bau_row_t r);
        logic [12:0] e;
        int          n;
        e = ref_op(op, r);
        bus(1'b1, `BAU_OFS_WREG, {24'h0, r.a}, rd);
        bus(1'b1, `BAU_OFS_FLAGS, {28'h0, r.f}, rd);
        bus(1'b1, `BAU_OFS_OPERAND, {24'h0, r.m}, rd);
        n = stb_cnt;
        bus(1'b1, `BAU_OFS_CTRL, {27'h0, op}, rd);
        bus(1'b0, `BAU_OFS_WREG, 32'h0, rd);
        chk(rd, {24'h0, e[12] ? r.a : e[7:0]});
        chk(32'(stb_cnt - n), {31'h0, e[12]});
        if (e[12]) begin
            chk({24'h0, stb_data}, {24'h0, e[7:0]});
            bus(1'b0, `BAU_OFS_MEMRES, 32'h0, rd);
            chk(rd, {24'h0, e[7:0]});
        end
        bus(1'b0, `BAU_OFS_FLAGS, 32'h0, rd);
        chk(rd, {28'h0, e[11:8]});
        bus(1'b0, `BAU_OFS_STATUS, 32'h0, rd);
        chk(rd, {30'h0, (op != 5'h00), e[12]});
    endtask

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int op = 0; op < 20; op++)
            for (int r = 0; r < 4; r++)
                run_row(op[4:0], rows[r]);
        bus(1'b1, `BAU_OFS_WREG, 32'h0000_00A5, rd);
        bus(1'b1, `BAU_OFS_MULOP, 32'h0000_005A, rd);
        bus(1'b1, `BAU_OFS_FLAGS, 32'h0000_000F, rd);
        bus(1'b1, `BAU_OFS_CTRL, {27'h0, `BAU_OP_MUL}, rd);
        bus(1'b1, `BAU_OFS_MULRH, 32'h0000_0077, rd);
        bus(1'b0, `BAU_OFS_MULRH, 32'h0, rd);
        chk(rd, 32'h0000_003A);
        bus(1'b0, `BAU_OFS_FLAGS, 32'h0, rd);
        chk(rd, 32'h0000_000F);
        bus(1'b0, `BAU_OFS_CTRL, 32'h0, rd);
        chk(rd, {27'h0, `BAU_OP_MUL});
        bus(1'b0, `BAU_OFS_STATUS, 32'h0, rd);
        chk(rd, 32'h0000_0002);
        // Freeze the clock enable during a pending read
        clk_en <= 1'b0;
        fork
            bus(1'b0, `BAU_OFS_WREG, 32'h0, rd);
            begin
                repeat (4) @(posedge sys_clk);
                clk_en <= 1'b1;
            end
        join
        chk(rd, 32'h0000_0002);
        bus(1'b1, `BAU_OFS_OPERAND, 32'h0000_0011, rd);
        avs_byteenable <= 4'hE;
        bus(1'b1, `BAU_OFS_OPERAND, 32'h0000_0022, rd);
        avs_byteenable <= 4'hF;
        bus(1'b0, `BAU_OFS_OPERAND, 32'h0, rd);
        chk(rd, 32'h0000_0011);
        bus(1'b0, 8'h20, 32'h0, rd);
        chk(rd, 32'h0);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, rst_ofs[i], 32'h0, rd);
            chk(rd, `BAU_RST_WORD);
        end
        stop_test;
    end
endmodule

bind bau_core bau_core_properties u_props (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_wr_data(mem_wr_data), .mem_wr_stb(mem_wr_stb));
`default_nettype wire
